/* src/ddt_ctl.sv */
// ddt_ctl: controller end, issues commands within latency limits
// assumes: device on the same core_clk, user holds a request until ready
`timescale 1ns/1ps
module ddt_ctl #(
    parameter int WR_NS = 15,
    parameter int REF_PD_CK = 1,
    parameter int XPDLL_CK = 24,
    parameter int PR_RECOV_CK = 1,
    parameter int REFI_CK = ddt_pkg::REFI_CK
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    ddt_link_if.ctl link,
    input wire logic req_valid,
    input wire ddt_pkg::ddt_op_t req_op,
    input wire logic req_chop,
    input wire logic [3:0] req_wl,
    input wire logic [1:0] req_blm,
    input wire logic req_dyn,
    input wire logic req_pattern,
    output logic req_ready,
    output logic ref_due
);
    // write recovery in cycles, rounded up
    localparam int WR_CK_I = (WR_NS + ddt_pkg::CLK_PERIOD_NS - 1)
        / ddt_pkg::CLK_PERIOD_NS;

    if (WR_CK_I < 1 || WR_CK_I > 15 || REF_PD_CK < 1 || REF_PD_CK > 255
        || XPDLL_CK < 1 || XPDLL_CK > 255 || PR_RECOV_CK < 1
        || PR_RECOV_CK > 200 || REFI_CK < 1 || REFI_CK > 1023)
    begin : g_chk
        $error("ddt_ctl: parameter out of range");
    end

    typedef enum logic [2:0] {
        ST_RUN = 3'b001,
        ST_PD = 3'b010,
        ST_SR = 3'b100
    } ddt_ctl_st_t;

    ddt_ctl_st_t st_r;
    ddt_ctl_st_t st_nxt;
    logic cke_r;
    logic cke_nxt;
    logic odt_r;
    logic odt_nxt;
    ddt_pkg::ddt_cmd_t cmd_r;
    ddt_pkg::ddt_cmd_t cmd_nxt;
    logic chop_r;
    logic chop_nxt;
    logic [ddt_pkg::MR_W-1:0] mr_r;
    logic [ddt_pkg::MR_W-1:0] mr_nxt;
    logic [3:0] wl_r;
    logic [3:0] wl_nxt;
    logic [3:0] wr_r;
    logic [3:0] wr_nxt;
    logic pat_r;
    logic pat_nxt;
    logic [3:0] gap_r;
    logic [3:0] gap_nxt;
    logic [2:0] burst_r;
    logic [2:0] burst_nxt;
    logic [4:0] wpd_r;
    logic [4:0] wpd_nxt;
    logic [7:0] refpd_r;
    logic [7:0] refpd_nxt;
    logic [7:0] xp_r;
    logic [7:0] xp_nxt;
    logic [7:0] prr_r;
    logic [7:0] prr_nxt;
    logic [9:0] refi_r;
    logic [9:0] refi_nxt;
    logic gap_ok;
    logic run;
    logic idle;
    logic dll_ok;
    logic ref_go;
    logic fire;

    assign run = st_r == ST_RUN;
    assign ref_due = refi_r == 10'(REFI_CK);
    assign idle = burst_r == 3'h0;
    assign dll_ok = link.dll_locked && xp_r == 8'h00;
    // next change at least wl-1 edges after the last one
    assign gap_ok = ({1'b0, gap_r} + 5'h01)
        >= {1'b0, wl_r - ddt_pkg::PD_GAP_SUB};
    assign ref_go = run && ref_due && idle;
    assign fire = req_valid && req_ready && !ref_go;

    always_comb begin
        case (req_op)
            ddt_pkg::OP_NOP: req_ready = 1'b1;
            ddt_pkg::OP_ACT,
            ddt_pkg::OP_PRE,
            ddt_pkg::OP_SHORT_IMPEDANCE_CALIBRATION: req_ready = run && !ref_due;
            ddt_pkg::OP_RD: req_ready = run && !ref_due && idle && dll_ok;
            ddt_pkg::OP_WR: req_ready = run && !ref_due && idle;
            ddt_pkg::OP_MRS: req_ready = run && !ref_due && idle
                && prr_r == 8'h00
                && req_wl >= ddt_pkg::WL_MIN && req_wl <= ddt_pkg::WL_MAX;
            ddt_pkg::OP_ODT_ON,
            ddt_pkg::OP_ODT_OFF: req_ready = st_r != ST_SR
                && gap_ok && dll_ok;
            ddt_pkg::OP_PD_ENTER: req_ready = run && !ref_due && idle
                && gap_ok && wpd_r == 5'h00
                && refpd_r == 8'h00;
            ddt_pkg::OP_PD_EXIT: req_ready = st_r == ST_PD && gap_ok;
            ddt_pkg::OP_SR_ENTER: req_ready = run && idle
                && wpd_r == 5'h00;
            ddt_pkg::OP_SR_EXIT: req_ready = st_r == ST_SR;
            default: req_ready = 1'b0;
        endcase
    end

    always_comb begin
        st_nxt = st_r;
        cke_nxt = cke_r;
        odt_nxt = odt_r;
        cmd_nxt = ddt_pkg::CMD_NOP;
        chop_nxt = 1'b0;
        mr_nxt = mr_r;
        wl_nxt = wl_r;
        wr_nxt = wr_r;
        pat_nxt = pat_r;
        gap_nxt = (gap_r == 4'he) ? gap_r : gap_r + 4'h1;
        burst_nxt = idle ? burst_r : burst_r - 3'h1;
        wpd_nxt = (wpd_r == 5'h00) ? wpd_r : wpd_r - 5'h01;
        refpd_nxt = (refpd_r == 8'h00) ? refpd_r : refpd_r - 8'h01;
        xp_nxt = (xp_r == 8'h00) ? xp_r : xp_r - 8'h01;
        prr_nxt = (prr_r == 8'h00) ? prr_r : prr_r - 8'h01;
        refi_nxt = ref_due ? refi_r : refi_r + 10'h001;
        if (ref_go) begin
            cmd_nxt = ddt_pkg::CMD_REF;
            refi_nxt = 10'h000;
            refpd_nxt = 8'(REF_PD_CK - 1);
        end else if (fire) begin
            case (req_op)
                ddt_pkg::OP_ACT: cmd_nxt = ddt_pkg::CMD_ACT;
                ddt_pkg::OP_PRE: cmd_nxt = ddt_pkg::CMD_PRE;
                ddt_pkg::OP_SHORT_IMPEDANCE_CALIBRATION: cmd_nxt = ddt_pkg::CMD_SHORT_IMPEDANCE_CALIBRATION;
                ddt_pkg::OP_RD: begin
                    cmd_nxt = ddt_pkg::CMD_RD;
                    chop_nxt = req_chop;
                    burst_nxt = ddt_pkg::BURST_GAP;
                    if (pat_r) begin
                        // recovery counted from end of pattern burst
                        prr_nxt = 8'(wl_r + ddt_pkg::RD_EXTRA
                            + ddt_pkg::WS_FULL) + 8'(PR_RECOV_CK - 1);
                    end
                end
                ddt_pkg::OP_WR: begin
                    cmd_nxt = ddt_pkg::CMD_WR;
                    chop_nxt = req_chop;
                    burst_nxt = ddt_pkg::BURST_GAP;
                    wpd_nxt = {1'b0, wl_r} + {1'b0, ddt_pkg::WS_FULL}
                        + {1'b0, wr_r} - 5'h01;
                end
                ddt_pkg::OP_MRS: begin
                    cmd_nxt = ddt_pkg::CMD_MRS;
                    mr_nxt = {req_pattern, 4'(WR_CK_I), req_dyn, req_blm,
                        req_wl};
                    wl_nxt = req_wl;
                    wr_nxt = 4'(WR_CK_I);
                    pat_nxt = req_pattern;
                end
                ddt_pkg::OP_ODT_ON,
                ddt_pkg::OP_ODT_OFF: begin
                    odt_nxt = req_op == ddt_pkg::OP_ODT_ON;
                    gap_nxt = 4'h0;
                end
                ddt_pkg::OP_PD_ENTER: begin
                    cke_nxt = 1'b0;
                    st_nxt = ST_PD;
                    gap_nxt = 4'h0;
                end
                ddt_pkg::OP_PD_EXIT: begin
                    cke_nxt = 1'b1;
                    st_nxt = ST_RUN;
                    gap_nxt = 4'h0;
                    xp_nxt = 8'(XPDLL_CK - 1);
                end
                ddt_pkg::OP_SR_ENTER: begin
                    cmd_nxt = ddt_pkg::CMD_REF;
                    cke_nxt = 1'b0;
                    st_nxt = ST_SR;
                    refi_nxt = 10'h000;
                end
                ddt_pkg::OP_SR_EXIT: begin
                    cke_nxt = 1'b1;
                    st_nxt = ST_RUN;
                    xp_nxt = 8'(XPDLL_CK - 1);
                end
                default: cmd_nxt = ddt_pkg::CMD_NOP;
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            st_r <= ST_RUN;
            cke_r <= 1'b1;
            odt_r <= 1'b0;
            cmd_r <= ddt_pkg::CMD_NOP;
            chop_r <= 1'b0;
            mr_r <= '0;
            wl_r <= ddt_pkg::WL_MIN;
            wr_r <= 4'(WR_CK_I);
            pat_r <= 1'b0;
            gap_r <= 4'he;
            burst_r <= 3'h0;
            wpd_r <= 5'h00;
            refpd_r <= 8'h00;
            xp_r <= 8'h00;
            prr_r <= 8'h00;
            refi_r <= 10'h000;
        end else if (clk_en) begin
            st_r <= st_nxt;
            cke_r <= cke_nxt;
            odt_r <= odt_nxt;
            cmd_r <= cmd_nxt;
            chop_r <= chop_nxt;
            mr_r <= mr_nxt;
            wl_r <= wl_nxt;
            wr_r <= wr_nxt;
            pat_r <= pat_nxt;
            gap_r <= gap_nxt;
            burst_r <= burst_nxt;
            wpd_r <= wpd_nxt;
            refpd_r <= refpd_nxt;
            xp_r <= xp_nxt;
            prr_r <= prr_nxt;
            refi_r <= refi_nxt;
        end
    end

    assign link.cke = cke_r;
    assign link.odt = odt_r;
    assign link.cmd = cmd_r;
    assign link.chop = chop_r;
    assign link.mr_data = mr_r;
endmodule : ddt_ctl

/* src/ddt_dev.sv */
// ddt_dev: memory-device end, termination latency and write timing
// assumes: controller on the same core_clk, one command per cycle
//
// What this block does
// - termination follows input after wl minus two
// - controller spaces termination and power-down changes
// - nominal to write termination at wl-2
// - chopped write returns nominal by 4+off delay
// - full write returns nominal by 6+off delay
// - full or otf chop starts write wl+4
// - fixed chop starts internal write at wl+2
// - reads and odt changes only with dll locked
// - short calibration cuts error within 64 cycles
// - clock enable low accepted while device busy
// - refresh to power-down waits required delays
// - write recovery cycles rounded up from time
// - controller uses programmed write recovery cycles
// - clock periods of 8 to 7800 ns if refresh kept
// - pattern recovery counted from pattern burst end
// - termination off throughout self refresh
// - bursts never interrupted once issued
`timescale 1ns/1ps
module ddt_dev #(
    parameter int LOCK_CK = 512,
    parameter int BUSY_CK = 8,
    parameter logic [7:0] ERR_INIT = 8'h20
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic clk_en,
    ddt_link_if.dev link,
    input wire logic drift_up,
    output logic [1:0] term_state,
    output logic write_start,
    output logic low_power,
    output logic self_refresh,
    output logic zq_busy,
    output logic [7:0] imp_err
);
    localparam int HW = ddt_pkg::HIST_W;

    if (LOCK_CK < 1 || LOCK_CK > 1023 || BUSY_CK < 1 || BUSY_CK > 255)
    begin : g_chk
        $error("ddt_dev: parameter out of range");
    end

    // mode and power state
    logic [3:0] wl_r;
    logic [3:0] wl_nxt;
    logic [1:0] blm_r;
    logic [1:0] blm_nxt;
    logic dyn_r;
    logic dyn_nxt;
    logic sr_r;
    logic sr_nxt;
    logic pd_r;
    logic pd_nxt;
    logic lp_r;
    logic lp_nxt;
    logic cke_q_r;
    logic cke_q_nxt;
    logic [7:0] busy_r;
    logic [7:0] busy_nxt;
    logic [9:0] lock_r;
    logic [9:0] lock_nxt;
    logic take;
    logic [3:0] mr_wl;

    // termination and write pipelines
    logic [HW-1:0] odt_h_r;
    logic [HW-1:0] odt_h_nxt;
    logic [HW-1:0] wr_h_r;
    logic [HW-1:0] wr_h_nxt;
    logic [HW-1:0] ch_h_r;
    logic [HW-1:0] ch_h_nxt;
    logic [2:0] wt_r;
    logic [2:0] wt_nxt;
    logic [1:0] term_r;
    logic [1:0] term_nxt;
    logic ws_r;
    logic ws_nxt;
    logic [3:0] d_idx;
    logic [3:0] ws_idx;
    logic start;
    logic chop_now;

    // calibration
    logic [6:0] zq_r;
    logic [6:0] zq_nxt;
    logic [7:0] err_r;
    logic [7:0] err_nxt;

    assign take = cke_q_r && link.cke && !sr_r;
    assign mr_wl = link.mr_data[ddt_pkg::MR_WL_LSB +: 4];

    always_comb begin
        wl_nxt = wl_r;
        blm_nxt = blm_r;
        dyn_nxt = dyn_r;
        if (take && link.cmd == ddt_pkg::CMD_MRS) begin
            if (mr_wl >= ddt_pkg::WL_MIN && mr_wl <= ddt_pkg::WL_MAX) begin
                wl_nxt = mr_wl;
            end
            blm_nxt = link.mr_data[ddt_pkg::MR_BLM_LSB +: 2];
            dyn_nxt = link.mr_data[ddt_pkg::MR_DYN_BIT];
        end
        cke_q_nxt = link.cke;
        sr_nxt = sr_r;
        pd_nxt = pd_r;
        if (sr_r) begin
            // self refresh ends when clock enable returns
            sr_nxt = !link.cke;
        end else if (cke_q_r && !link.cke) begin
            if (link.cmd == ddt_pkg::CMD_REF) begin
                sr_nxt = 1'b1;
            end else begin
                pd_nxt = 1'b1;
            end
        end else if (pd_r && link.cke) begin
            pd_nxt = 1'b0;
        end
        // activate, precharge and refresh keep running into power-down
        if (take && (link.cmd == ddt_pkg::CMD_ACT
                || link.cmd == ddt_pkg::CMD_PRE
                || link.cmd == ddt_pkg::CMD_REF)) begin
            busy_nxt = 8'(BUSY_CK);
        end else if (busy_r != 8'h00) begin
            busy_nxt = busy_r - 8'h01;
        end else begin
            busy_nxt = busy_r;
        end
        lp_nxt = pd_nxt && busy_nxt == 8'h00;
        // dll relocks after self refresh
        if (sr_r) begin
            lock_nxt = 10'h000;
        end else if (lock_r != 10'(LOCK_CK)) begin
            lock_nxt = lock_r + 10'h001;
        end else begin
            lock_nxt = lock_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            wl_r <= ddt_pkg::WL_MIN;
            blm_r <= ddt_pkg::BL_FIXED8;
            dyn_r <= 1'b0;
            sr_r <= 1'b0;
            pd_r <= 1'b0;
            lp_r <= 1'b0;
            cke_q_r <= 1'b0;
            busy_r <= 8'h00;
            lock_r <= 10'h000;
        end else if (clk_en) begin
            wl_r <= wl_nxt;
            blm_r <= blm_nxt;
            dyn_r <= dyn_nxt;
            sr_r <= sr_nxt;
            pd_r <= pd_nxt;
            lp_r <= lp_nxt;
            cke_q_r <= cke_q_nxt;
            busy_r <= busy_nxt;
            lock_r <= lock_nxt;
        end
    end

    always_comb begin
        // all latencies taken from the live write latency
        d_idx = wl_r - ddt_pkg::TERM_SUB - 4'h1;
        if (blm_r == ddt_pkg::BL_FIXED4) begin
            ws_idx = wl_r + ddt_pkg::WS_CHOP - 4'h1;
        end else begin
            ws_idx = wl_r + ddt_pkg::WS_FULL - 4'h1;
        end
        chop_now = blm_r == ddt_pkg::BL_FIXED4
            || (blm_r == ddt_pkg::BL_OTF && link.chop);
        odt_h_nxt = {odt_h_r[HW-2:0], link.odt};
        wr_h_nxt = {wr_h_r[HW-2:0], take && link.cmd == ddt_pkg::CMD_WR};
        ch_h_nxt = {ch_h_r[HW-2:0], chop_now};
        start = dyn_r && wr_h_r[d_idx];
        if (start) begin
            if (ch_h_r[d_idx]) begin
                wt_nxt = ddt_pkg::CHOP_TAIL - 3'h1;
            end else begin
                wt_nxt = ddt_pkg::FULL_TAIL - 3'h1;
            end
        end else if (wt_r != 3'h0) begin
            wt_nxt = wt_r - 3'h1;
        end else begin
            wt_nxt = wt_r;
        end
        if (sr_nxt) begin
            term_nxt = ddt_pkg::TERM_OFF;
        end else if (!odt_h_r[d_idx]) begin
            term_nxt = ddt_pkg::TERM_OFF;
        end else if (start || wt_r != 3'h0) begin
            term_nxt = ddt_pkg::TERM_WRITE;
        end else begin
            term_nxt = ddt_pkg::TERM_NOM;
        end
        ws_nxt = wr_h_r[ws_idx];
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            odt_h_r <= '0;
            wr_h_r <= '0;
            ch_h_r <= '0;
            wt_r <= 3'h0;
            term_r <= ddt_pkg::TERM_OFF;
            ws_r <= 1'b0;
        end else if (clk_en) begin
            odt_h_r <= odt_h_nxt;
            wr_h_r <= wr_h_nxt;
            ch_h_r <= ch_h_nxt;
            wt_r <= wt_nxt;
            term_r <= term_nxt;
            ws_r <= ws_nxt;
        end
    end

    always_comb begin
        if (take && link.cmd == ddt_pkg::CMD_SHORT_IMPEDANCE_CALIBRATION && zq_r == 7'h00) begin
            zq_nxt = ddt_pkg::SHORT_IMPEDANCE_CALIBRATION_CK;
        end else if (zq_r != 7'h00) begin
            zq_nxt = zq_r - 7'h01;
        end else begin
            zq_nxt = zq_r;
        end
        // correction lands on the 64th edge after the command
        if (zq_r == 7'h01) begin
            if (err_r > ddt_pkg::ZQ_STEP) begin
                err_nxt = err_r - ddt_pkg::ZQ_STEP;
            end else begin
                err_nxt = 8'h00;
            end
        end else if (drift_up && err_r != 8'hff) begin
            err_nxt = err_r + 8'h01;
        end else begin
            err_nxt = err_r;
        end
    end

    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            zq_r <= 7'h00;
            err_r <= ERR_INIT;
        end else if (clk_en) begin
            zq_r <= zq_nxt;
            err_r <= err_nxt;
        end
    end

    assign link.dll_locked = lock_r == 10'(LOCK_CK);
    assign term_state = term_r;
    assign write_start = ws_r;
    assign low_power = lp_r;
    assign self_refresh = sr_r;
    assign zq_busy = zq_r != 7'h00;
    assign imp_err = err_r;
endmodule : ddt_dev

/* src/ddt_link_if.sv */
// ddt_link_if: command link between controller and memory device
// assumes: both ends clocked by the same core_clk
`timescale 1ns/1ps
interface ddt_link_if;
    logic cke;
    logic odt;
    ddt_pkg::ddt_cmd_t cmd;
    logic chop;
    logic [ddt_pkg::MR_W-1:0] mr_data;
    logic dll_locked;

    modport dev (
        input cke,
        input odt,
        input cmd,
        input chop,
        input mr_data,
        output dll_locked
    );

    modport ctl (
        output cke,
        output odt,
        output cmd,
        output chop,
        output mr_data,
        input dll_locked
    );
endinterface : ddt_link_if

/* src/ddt_pkg.sv */
// ddt_pkg: shared constants and types for the termination/latency link
// assumes: both ends run on core_clk at 100 MHz
package ddt_pkg;
    localparam int CLK_PERIOD_NS = 10;
    // average refresh interval, longest time so rounded down
    localparam int REFI_NS = 7800;
    localparam int REFI_CK = REFI_NS / CLK_PERIOD_NS;
    // depth of the latency pipelines
    localparam int HIST_W = 16;
    localparam logic [3:0] WL_MIN = 4'h5;
    localparam logic [3:0] WL_MAX = 4'h8;
    // term_on_delay = term_off_delay = nominal_to_write_term_delay = wl-2
    localparam logic [3:0] TERM_SUB = 4'h2;
    // termination to power-down spacing is wl-1
    localparam logic [3:0] PD_GAP_SUB = 4'h1;
    // write termination tails after the switch point
    localparam logic [2:0] CHOP_TAIL = 3'h4;
    localparam logic [2:0] FULL_TAIL = 3'h6;
    // internal write start after write latency
    localparam logic [3:0] WS_FULL = 4'h4;
    localparam logic [3:0] WS_CHOP = 4'h2;
    localparam logic [6:0] SHORT_IMPEDANCE_CALIBRATION_CK = 7'h40;
    // impedance error in tenths of a percent
    localparam logic [7:0] ZQ_STEP = 8'h05;
    // read latency is write latency plus one
    localparam logic [3:0] RD_EXTRA = 4'h1;
    // burst spacing, four cycles, held as count minus one
    localparam logic [2:0] BURST_GAP = 3'h3;
    // mode register payload layout
    localparam int MR_W = 12;
    localparam int MR_WL_LSB = 0;
    localparam int MR_BLM_LSB = 4;
    localparam int MR_DYN_BIT = 6;
    localparam int MR_WR_LSB = 7;
    localparam int MR_PAT_BIT = 11;
    localparam logic [1:0] BL_FIXED8 = 2'h0;
    localparam logic [1:0] BL_OTF = 2'h1;
    localparam logic [1:0] BL_FIXED4 = 2'h2;
    localparam logic [1:0] TERM_OFF = 2'h0;
    localparam logic [1:0] TERM_NOM = 2'h1;
    localparam logic [1:0] TERM_WRITE = 2'h2;

    typedef enum logic [3:0] {
        CMD_NOP = 4'h0,
        CMD_ACT = 4'h1,
        CMD_PRE = 4'h2,
        CMD_RD = 4'h3,
        CMD_WR = 4'h4,
        CMD_REF = 4'h5,
        CMD_MRS = 4'h6,
        CMD_SHORT_IMPEDANCE_CALIBRATION = 4'h7
    } ddt_cmd_t;

    typedef enum logic [3:0] {
        OP_NOP = 4'h0,
        OP_ACT = 4'h1,
        OP_PRE = 4'h2,
        OP_RD = 4'h3,
        OP_WR = 4'h4,
        OP_MRS = 4'h5,
        OP_SHORT_IMPEDANCE_CALIBRATION = 4'h6,
        OP_ODT_ON = 4'h7,
        OP_ODT_OFF = 4'h8,
        OP_PD_ENTER = 4'h9,
        OP_PD_EXIT = 4'ha,
        OP_SR_ENTER = 4'hb,
        OP_SR_EXIT = 4'hc
    } ddt_op_t;
endpackage : ddt_pkg

/* verif/ddt_link_checker.sv */
// ddt_link_checker: timing checks on the controller-to-device link
// assumes: instantiated beside the link interface, one core_clk domain
`timescale 1ns/1ps
module ddt_link_checker #(
    parameter int XPDLL_CK = 24
) (
    input wire logic core_clk,
    input wire logic resetn,
    input wire logic cke,
    input wire logic odt,
    input wire ddt_pkg::ddt_cmd_t cmd,
    input wire logic chop,
    input wire logic [ddt_pkg::MR_W-1:0] mr_data,
    input wire logic dll_locked
);
    int gap_r, wr_r, up_r, wl, wr;
    logic rw;
    assign rw = cmd == ddt_pkg::CMD_RD || cmd == ddt_pkg::CMD_WR;
    assign wl = int'(mr_data[3:0]);
    assign wr = int'(mr_data[10:7]);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // edges since last odt/cke change, write, cke rise
    always_ff @(posedge core_clk) begin
        if (!resetn) begin
            gap_r <= 31;
            wr_r <= 31;
            up_r <= 63;
        end else begin
            gap_r <= ($changed(odt) || $changed(cke)) ? 0 :
                (gap_r < 31 ? gap_r + 1 : 31);
            wr_r <= cmd == ddt_pkg::CMD_WR ? 0 : (wr_r < 31 ? wr_r + 1 : 31);
            up_r <= $rose(cke) ? 0 : (up_r < 63 ? up_r + 1 : 63);
        end
    end
    property p_odt_gap;
        $changed(odt) |-> gap_r >= wl - 2;
    endproperty
    a_odt_gap: assert property (p_odt_gap)
        else $error("odt changed too soon");
    property p_rd_lock;
        cmd == ddt_pkg::CMD_RD |-> dll_locked;
    endproperty
    a_rd_lock: assert property (p_rd_lock)
        else $error("read without locked dll");
    property p_odt_lock;
        $rose(odt) |-> dll_locked;
    endproperty
    a_odt_lock: assert property (p_odt_lock)
        else $error("odt without locked dll");
    property p_burst_gap;
        rw |=> !rw [*3];
    endproperty
    a_burst_gap: assert property (p_burst_gap)
        else $error("burst interrupted");
    property p_chop_pair;
        chop |-> rw;
    endproperty
    a_chop_pair: assert property (p_chop_pair)
        else $error("chop without burst");
    property p_mrs_wl;
        cmd == ddt_pkg::CMD_MRS |-> wl >= 5 && wl <= 8;
    endproperty
    a_mrs_wl: assert property (p_mrs_wl)
        else $error("illegal write latency");
    property p_wr_pd;
        $fell(cke) |-> wr_r >= wl + 4 + wr - 1;
    endproperty
    a_wr_pd: assert property (p_wr_pd)
        else $error("power-down too soon after write");
    property p_xpdll;
        cmd == ddt_pkg::CMD_RD |-> up_r >= XPDLL_CK - 1;
    endproperty
    a_xpdll: assert property (p_xpdll)
        else $error("read too soon after exit");
    c_wr: cover property (cmd == ddt_pkg::CMD_WR && chop);
    c_rd: cover property (cmd == ddt_pkg::CMD_RD);
    c_pd: cover property ($fell(cke));
    c_zq: cover property (cmd == ddt_pkg::CMD_SHORT_IMPEDANCE_CALIBRATION);
endmodule : ddt_link_checker

/* verif/testbench.sv */
// testbench: both link ends joined, user side driven, device observed
// assumes: shortened lock and refresh counts
`timescale 1ns/1ps
module testbench;
    logic core_clk = 1'b0;
    logic resetn = 1'b0;
    logic drift_up = 1'b0;
    logic req_valid = 1'b0;
    ddt_pkg::ddt_op_t req_op = ddt_pkg::OP_NOP;
    logic req_chop = 1'b0;
    logic [3:0] req_wl = 4'h5;
    logic [1:0] req_blm = 2'h0;
    logic req_dyn = 1'b0, req_pattern = 1'b0, clk_en = 1'b1;
    logic req_ready, ref_due, write_start, low_power, self_refresh, zq_busy;
    logic [1:0] term_state;
    logic [7:0] imp_err;
    int err_count = 0;
    int n_tests = 0;
    int seed = 32'hb25520e0;
    int wl_m, n, k;
    logic [1:0] blm_m;
    always #5 core_clk = ~core_clk;
    ddt_link_if i_ddt_link_if ();
    ddt_dev #(.LOCK_CK(16), .ERR_INIT(8'h20)) i_ddt_dev (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .link(i_ddt_link_if), .drift_up(drift_up), .term_state(term_state),
        .write_start(write_start), .low_power(low_power),
        .self_refresh(self_refresh), .zq_busy(zq_busy), .imp_err(imp_err));
    ddt_ctl #(.REFI_CK(40)) i_ddt_ctl (
        .core_clk(core_clk), .resetn(resetn), .clk_en(clk_en),
        .link(i_ddt_link_if), .req_valid(req_valid), .req_op(req_op),
        .req_chop(req_chop), .req_wl(req_wl), .req_blm(req_blm),
        .req_dyn(req_dyn), .req_pattern(req_pattern), .req_ready(req_ready),
        .ref_due(ref_due));
    ddt_link_checker #(.XPDLL_CK(24)) i_ddt_link_checker (
        .core_clk(core_clk), .resetn(resetn), .cke(i_ddt_link_if.cke),
        .odt(i_ddt_link_if.odt), .cmd(i_ddt_link_if.cmd),
        .chop(i_ddt_link_if.chop), .mr_data(i_ddt_link_if.mr_data),
        .dll_locked(i_ddt_link_if.dll_locked));
    task print_verdict;
        $display("checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask : print_verdict
    task chk_int(string nm, int e, int g);
        n_tests++;
        if (e != g) begin
            err_count++;
            $display("MISMATCH %s exp %0d got %0d", nm, e, g);
        end
    endtask : chk_int
    task chk_bits(string nm, logic [7:0] e, logic [7:0] g);
        n_tests++;
        if (e !== g) begin
            err_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask : chk_bits
    function int exp_start(int wl, logic [1:0] blm);
        return wl + 1 + int'(blm == ddt_pkg::BL_FIXED4 ?
            ddt_pkg::WS_CHOP : ddt_pkg::WS_FULL);
    endfunction : exp_start
    function int exp_tail(logic [1:0] blm, logic ch);
        return (blm == ddt_pkg::BL_FIXED4 || (blm == ddt_pkg::BL_OTF && ch)) ?
            int'(ddt_pkg::CHOP_TAIL) : int'(ddt_pkg::FULL_TAIL);
    endfunction : exp_tail
    task do_req(ddt_pkg::ddt_op_t op, logic ch);
        int i;
        @(posedge core_clk);
        #1;
        req_op = op;
        req_chop = ch;
        req_valid = 1'b1;
        for (i = 0; i < 400; i++) begin
            @(negedge core_clk);
            if (req_ready === 1'b1 && (ref_due === 1'b0
                || op == ddt_pkg::OP_PD_EXIT)) break;
        end
        if (i == 400) begin
            err_count++;
            print_verdict();
        end else begin
            @(posedge core_clk);
            #1;
            req_valid = 1'b0;
        end
    endtask : do_req
    task meas_term(logic [1:0] tgt, output int c);
        for (c = 1; c < 60; c++) begin
            @(posedge core_clk);
            #1;
            if (term_state === tgt) break;
        end
    endtask : meas_term
    task wr_chk(logic ch);
        int t_w, t_n, t_s;
        t_w = 0;
        t_n = 0;
        t_s = 0;
        do_req(ddt_pkg::OP_WR, ch);
        for (int i = 1; i < 40; i++) begin
            @(posedge core_clk);
            #1;
            if (term_state === ddt_pkg::TERM_WRITE && t_w == 0) t_w = i;
            if (t_w > 0 && t_n == 0 && term_state === ddt_pkg::TERM_NOM)
                t_n = i;
            if (write_start === 1'b1) t_s = i;
        end
        chk_int("write term", wl_m - 1, t_w);
        chk_int("nominal back", exp_tail(blm_m, ch), t_n - t_w);
        chk_int("write start", exp_start(wl_m, blm_m), t_s);
    endtask : wr_chk
    initial begin
        repeat (10) @(posedge core_clk);
        #1;
        resetn = 1'b1;
        repeat (20) @(posedge core_clk);
        k = {$random(seed)} % 8;
        repeat (k) begin
            @(posedge core_clk);
            #1;
            drift_up = 1'b1;
            @(posedge core_clk);
            #1;
            drift_up = 1'b0;
        end
        do_req(ddt_pkg::OP_SHORT_IMPEDANCE_CALIBRATION, 1'b0);
        clk_en = 1'b0;
        repeat (3) @(posedge core_clk);
        #1 clk_en = 1'b1;
        n = 0;
        repeat (80) begin
            @(posedge core_clk);
            #1;
            if (zq_busy === 1'b1) n++;
        end
        chk_int("zq busy", int'(ddt_pkg::SHORT_IMPEDANCE_CALIBRATION_CK), n);
        chk_bits("imp err", 8'(8'h20 + k - ddt_pkg::ZQ_STEP), imp_err);
        for (int j = 0; j < 8; j++) begin
            wl_m = j == 0 ? 8 : (j == 1 ? 5 : 5 + {$random(seed)} % 4);
            blm_m = j < 3 ? 2'(j) : 2'({$random(seed)} % 3);
            req_wl = 4'(wl_m);
            req_blm = blm_m;
            req_dyn = 1'b1;
            do_req(ddt_pkg::OP_MRS, 1'b0);
            do_req(ddt_pkg::OP_ODT_ON, 1'b0);
            meas_term(ddt_pkg::TERM_NOM, n);
            chk_int("term on", wl_m - 1, n);
            wr_chk(j == 1 ? 1'b1 : 1'($random(seed)));
            do_req(ddt_pkg::OP_ODT_OFF, 1'b0);
            meas_term(ddt_pkg::TERM_OFF, n);
            chk_int("term off", wl_m - 1, n);
        end
        do_req(ddt_pkg::OP_ACT, 1'b0);
        do_req(ddt_pkg::OP_PD_ENTER, 1'b0);
        repeat (20) @(posedge core_clk);
        chk_bits("low power", 8'h01, {7'h0, low_power});
        do_req(ddt_pkg::OP_PD_EXIT, 1'b0);
        do_req(ddt_pkg::OP_RD, 1'b0);
        do_req(ddt_pkg::OP_ODT_ON, 1'b0);
        meas_term(ddt_pkg::TERM_NOM, n);
        do_req(ddt_pkg::OP_SR_ENTER, 1'b0);
        repeat (4) @(posedge core_clk);
        chk_bits("sr term", 8'h04, {5'h0, self_refresh, term_state});
        do_req(ddt_pkg::OP_SR_EXIT, 1'b0);
        print_verdict();
    end
endmodule : testbench
